// File: logic/ripl_defines.svh
// constants for the remote load sequencer
`ifndef RIPL_DEFINES_SVH
`define RIPL_DEFINES_SVH
`define RIPL_CTRL_OFS 32'h0000_0000
`define RIPL_STAT_OFS 32'h0000_0004
`define RIPL_IRQ_STAT_OFS 32'h0000_0008
`define RIPL_IRQ_CLR_OFS 32'h0000_000C
`define RIPL_IRQ_EN_OFS 32'h0000_0010
`define RIPL_ERR_OFS 32'h0000_0014
`define RIPL_CTRL_START_BIT 2
`define RIPL_CTRL_SELRPL_BIT 4
`define RIPL_CTRL_BOOTERR_BIT 8
`define RIPL_BOOT_BYTES 11'h400
`define RIPL_BOOT_BASE 20'h0_0000
`define RIPL_BOOT_ENTRY 20'h0_0010
`define RIPL_RESET_CYCLES 4'h8
`define RIPL_IRQ_BITS 4
`endif

// File: logic/ripl_pkg.sv
// types for the remote load sequencer
package ripl_pkg;
  typedef enum logic [2:0]
  {
    RIPL_IDLE = 3'b000,
    RIPL_PH1 = 3'b001,
    RIPL_PH2 = 3'b010,
    RIPL_PH3 = 3'b011,
    RIPL_RUN = 3'b100,
    RIPL_HSTOP = 3'b101
  } ripl_state_t;
  typedef struct packed
  {
    logic load_ind;
    logic ph1_ind;
    logic ph2_ind;
    logic test_ind;
    logic hard_stop;
    logic rom_sel;
  } ripl_panel_t;
  typedef struct packed
  {
    logic key0_clear;
    logic mask_l2_5;
    logic unmask_l1;
    logic clr_latches;
    logic block_store;
    logic l1_request;
  } ripl_ccu_t;
endpackage

// File: logic/ripl_copy.sv
// cycle steal copier: one byte per storage cycle from rom to main storage
`timescale 1ns/10ps
`default_nettype none
`include "ripl_defines.svh"
module ripl_copy
#(
  parameter int NBYTES = 1024
)
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control
  input wire logic start,
  output logic done,
  // rom side
  output logic [9:0] rom_addr,
  input wire logic [7:0] rom_data,
  // storage cycle steal side
  output logic cs_req,
  output logic [19:0] cs_addr,
  output logic [7:0] cs_data,
  input wire logic cs_ack
);
  typedef struct packed
  {
    logic busy;
    logic done;
    logic [10:0] cnt;
  } ripl_copy_st_t;
  ripl_copy_st_t st_r, st_nxt;
  // next state: one byte moves per acknowledged storage cycle
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.done = 1'b0;
    if (start && !st_r.busy)
    begin
      st_nxt.busy = 1'b1;
      st_nxt.cnt = 11'h000;
    end
    else if (st_r.busy && cs_ack)
    begin
      // exactly one byte per acknowledge
      st_nxt.cnt = st_r.cnt + 11'h001;
      if (st_r.cnt == 11'(NBYTES - 1))
      begin
        st_nxt.busy = 1'b0;
        st_nxt.done = 1'b1;
      end
    end
  end
  // state register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end
  assign done = st_r.done;
  assign rom_addr = st_r.cnt[9:0];
  assign cs_req = st_r.busy;
  // destination starts at the bootstrap base
  assign cs_addr = `RIPL_BOOT_BASE + {10'h000, st_r.cnt[9:0]};
  assign cs_data = rom_data;
endmodule
`default_nettype wire

// File: logic/ripl_seq.sv
// remote load sequencer top: start decode, three phases, ahb-lite registers
//
// Function
// - accept starts only in normal run position
// - start on load, power-on, or unit check
// - program output start bit begins load
// - program start selects loader rom if latched
// - all adapters disabled selects loader rom; the code also requires adapter_switches_off
// - phase 1 lights load, phase1, resets unit
// - reset clears first key, lights test
// - mask levels two to five, unmask one
// - clear latches, requests, stops; block storage
// - phase 1 indicator off when reset completes
// - copy 1024 bytes to address zero
// - cycle steal moves one byte per cycle
// - phase 2 indicator off after copy
// - phase 3 lights both, raises level one
// - bootstrap begins at address sixteen hex
// - bootstrap error gives hard stop, code shown
//
// The implementer's own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ripl_defines.svh"
module ripl_seq
#(
  parameter int NBYTES = 1024,
  parameter logic [3:0] RESET_CYCLES = `RIPL_RESET_CYCLES
)
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // panel and unit inputs
  input wire logic diag_process,
  input wire logic load_button,
  input wire logic power_on_button,
  input wire logic unit_check,
  input wire logic adapters_disabled,
  input wire logic adapter_switches_off,
  // rom and cycle steal
  output logic [9:0] rom_addr,
  input wire logic [7:0] rom_data,
  output logic cs_req,
  output logic [19:0] cs_addr,
  output logic [7:0] cs_data,
  input wire logic cs_ack,
  // panel indicators and unit controls
  output ripl_pkg::ripl_panel_t panel,
  output ripl_pkg::ripl_ccu_t central_control_unit,
  output logic [19:0] start_addr,
  output logic start_exec,
  output logic [7:0] err_display,
  output logic irq
);
  typedef struct packed
  {
    ripl_pkg::ripl_state_t state;
    ripl_pkg::ripl_panel_t panel;
    ripl_pkg::ripl_ccu_t central_control_unit;
    logic sel_latch;
    logic [3:0] rcnt;
    logic copy_go;
    logic exec;
    logic [19:0] saddr;
    logic [7:0] err;
    logic [3:0] ist;
    logic [3:0] ien;
    logic aphase;
    logic awr;
    logic [2:0] aidx;
    logic [31:0] rdata;
    logic irq; // registered so the pin comes straight off a flop
  } ripl_st_t;
  ripl_st_t s_r, s_nxt;
  logic copy_done;
  logic [9:0] c_rom_addr;
  logic c_cs_req;
  logic [19:0] c_cs_addr;
  logic [7:0] c_cs_data;
  logic [3:0] ev;
  logic button_start;
  logic prog_start;
  logic boot_err;
  logic wr_ctrl;
  logic addr_ok; // address inside the eight-word window
  // byte copier for phase 2
  ripl_copy #(.NBYTES(NBYTES)) u_copy
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(s_r.copy_go),
    .done(copy_done),
    .rom_addr(c_rom_addr),
    .rom_data(rom_data),
    .cs_req(c_cs_req),
    .cs_addr(c_cs_addr),
    .cs_data(c_cs_data),
    .cs_ack(cs_ack)
  );
  // decode helpers: data phase write, start buttons, address window
  always_comb
  begin
    wr_ctrl = s_r.aphase && s_r.awr && (s_r.aidx == 3'h0);
    prog_start = wr_ctrl && hwdata[`RIPL_CTRL_START_BIT];
    boot_err = wr_ctrl && hwdata[`RIPL_CTRL_BOOTERR_BIT];
    button_start = load_button || power_on_button || unit_check;
    // aliases above the window must not reach the control word
    addr_ok = (haddr[31:5] == 27'h000_0000);
  end
  // all next-state logic
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.copy_go = 1'b0;
    s_nxt.exec = 1'b0;
    ev = 4'h0;
    // bus address phase capture; slave is always zero wait
    s_nxt.aphase = hsel && hready && htrans[1] && addr_ok;
    if (hsel && hready && htrans[1] && addr_ok)
    begin
      s_nxt.awr = hwrite;
      s_nxt.aidx = haddr[4:2];
    end
    // latch program selection of the loader rom
    if (wr_ctrl)
      s_nxt.sel_latch = hwdata[`RIPL_CTRL_SELRPL_BIT];
    // sequencer
    unique case (s_r.state)
      ripl_pkg::RIPL_IDLE, ripl_pkg::RIPL_RUN, ripl_pkg::RIPL_HSTOP:
      begin
        // starts are ignored unless switch is in process position
        if (diag_process && (button_start || prog_start))
        begin
          s_nxt.state = ripl_pkg::RIPL_PH1;
          s_nxt.panel.load_ind = 1'b1;
          s_nxt.panel.ph1_ind = 1'b1;
          s_nxt.panel.ph2_ind = 1'b0;
          s_nxt.panel.hard_stop = 1'b0;
          // rom choice: latched program request, or no usable adapter
          s_nxt.panel.rom_sel = (prog_start && s_r.sel_latch)
            || (adapters_disabled && adapter_switches_off);
          // general reset is asserted from the first phase 1 cycle on
          s_nxt.central_control_unit = '0;
          s_nxt.central_control_unit.key0_clear = 1'b1;
          s_nxt.panel.test_ind = 1'b1;
          s_nxt.central_control_unit.mask_l2_5 = 1'b1;
          s_nxt.central_control_unit.unmask_l1 = 1'b1;
          s_nxt.central_control_unit.clr_latches = 1'b1;
          s_nxt.central_control_unit.block_store = 1'b1;
          s_nxt.rcnt = RESET_CYCLES;
          ev[0] = 1'b1;
        end
      end
      ripl_pkg::RIPL_PH1:
      begin
        // general reset held for a fixed number of cycles
        s_nxt.central_control_unit.key0_clear = 1'b1;
        s_nxt.panel.test_ind = 1'b1;
        s_nxt.central_control_unit.mask_l2_5 = 1'b1;
        s_nxt.central_control_unit.unmask_l1 = 1'b1;
        s_nxt.central_control_unit.clr_latches = 1'b1;
        s_nxt.central_control_unit.block_store = 1'b1;
        s_nxt.panel.hard_stop = 1'b0;
        s_nxt.rcnt = s_r.rcnt - 4'h1;
        if (s_r.rcnt == 4'h1)
        begin
          // reset done: indicator off, next phase only now
          s_nxt.panel.ph1_ind = 1'b0;
          s_nxt.central_control_unit.clr_latches = 1'b0;
          s_nxt.central_control_unit.block_store = 1'b0;
          s_nxt.panel.ph2_ind = 1'b1;
          s_nxt.copy_go = 1'b1;
          s_nxt.state = ripl_pkg::RIPL_PH2;
        end
      end
      ripl_pkg::RIPL_PH2:
      begin
        // indicator stays lit until the last byte lands
        if (copy_done)
        begin
          s_nxt.panel.ph2_ind = 1'b0;
          s_nxt.state = ripl_pkg::RIPL_PH3;
          ev[1] = 1'b1;
        end
      end
      ripl_pkg::RIPL_PH3:
      begin
        s_nxt.panel.ph1_ind = 1'b1;
        s_nxt.panel.ph2_ind = 1'b1;
        s_nxt.central_control_unit.l1_request = 1'b1;
        s_nxt.saddr = `RIPL_BOOT_ENTRY;
        s_nxt.exec = 1'b1;
        s_nxt.state = ripl_pkg::RIPL_RUN;
      end
      default:
      begin
        s_nxt.state = ripl_pkg::RIPL_IDLE;
      end
    endcase
    // bootstrap reports a first-section error: hard stop with code
    if (boot_err && (s_r.state == ripl_pkg::RIPL_RUN))
    begin
      s_nxt.panel.hard_stop = 1'b1;
      s_nxt.err = hwdata[23:16];
      s_nxt.state = ripl_pkg::RIPL_HSTOP;
      ev[2] = 1'b1;
    end
    ev[3] = unit_check && !s_r.ist[3];
    // sticky status: set wins over clear
    if (s_r.aphase && s_r.awr && (s_r.aidx == 3'h3))
      s_nxt.ist = s_r.ist & ~hwdata[3:0];
    s_nxt.ist = s_nxt.ist | ev;
    if (s_r.aphase && s_r.awr && (s_r.aidx == 3'h4))
      s_nxt.ien = hwdata[3:0];
    // level interrupt from the next status and enable
    s_nxt.irq = |(s_nxt.ist & s_nxt.ien);
    // read data, registered for the next data phase
    s_nxt.rdata = 32'h0000_0000;
    if (hsel && hready && htrans[1] && !hwrite && addr_ok)
    begin
      unique case (haddr[4:2])
        3'h0: s_nxt.rdata = {27'h000_0000, s_r.sel_latch, 4'h0};
        3'h1: s_nxt.rdata = {21'h00_0000, s_r.state, 2'h0, s_r.panel};
        3'h2: s_nxt.rdata = {28'h000_0000, s_r.ist};
        3'h4: s_nxt.rdata = {28'h000_0000, s_r.ien};
        3'h5: s_nxt.rdata = {24'h00_0000, s_r.err};
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end
  // state register
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
  // outputs
  assign hrdata = s_r.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign panel = s_r.panel;
  assign central_control_unit = s_r.central_control_unit;
  assign start_addr = s_r.saddr;
  assign start_exec = s_r.exec;
  assign err_display = s_r.err;
  assign irq = s_r.irq;
  assign rom_addr = c_rom_addr;
  assign cs_req = c_cs_req;
  assign cs_addr = c_cs_addr;
  assign cs_data = c_cs_data;
endmodule
`default_nettype wire

// File: verification/ripl_chk.sv
// port checker for the remote load sequencer
`timescale 1ns/10ps
`default_nettype none
module ripl_chk
#(
  parameter int NBYTES = 1024
)
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // panel switch
  input wire logic diag_process,
  // copy path
  input wire logic [7:0] rom_data,
  input wire logic cs_req,
  input wire logic [19:0] cs_addr,
  input wire logic [7:0] cs_data,
  input wire logic cs_ack,
  // indicators and unit controls
  input wire ripl_pkg::ripl_panel_t panel,
  input wire ripl_pkg::ripl_ccu_t central_control_unit,
  input wire logic [19:0] start_addr,
  input wire logic start_exec
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic in_ph1; // first phase alone is lit
  assign in_ph1 = panel.ph1_ind && !panel.ph2_ind;
  a_gate_start: assert property ($rose(panel.load_ind) |-> $past(diag_process))
    else $error("load began outside process position");
  a_load_lit: assert property ($rose(in_ph1) |-> panel.load_ind)
    else $error("load indicator dark in first phase");
  a_reset_keys: assert property (in_ph1 |-> central_control_unit.key0_clear && panel.test_ind)
    else $error("key or test indicator wrong in reset");
  a_mask_levels: assert property (in_ph1 |-> central_control_unit.mask_l2_5 && central_control_unit.unmask_l1)
    else $error("level masks wrong in reset");
  a_clear_block: assert property (in_ph1 |-> central_control_unit.clr_latches && central_control_unit.block_store)
    else $error("latches or storage not held in reset");
  a_ph1_len: assert property ($rose(in_ph1) |-> in_ph1[*8] ##1 (!panel.ph1_ind && panel.ph2_ind))
    else $error("first phase length or exit wrong");
  a_copy_phase: assert property (cs_req |-> panel.ph2_ind && !panel.ph1_ind && cs_addr < NBYTES)
    else $error("copy outside second phase");
  a_first_byte: assert property ($rose(cs_req) |-> cs_addr == 20'h0_0000)
    else $error("copy not starting at zero");
  a_byte_step: assert property (cs_req && cs_ack |=> !cs_req || cs_addr == $past(cs_addr) + 20'h0_0001)
    else $error("address step per byte wrong");
  a_data_path: assert property (cs_req |-> cs_data == rom_data)
    else $error("copied byte differs from rom");
  a_ph2_done: assert property ($fell(cs_req) |-> ##[0:3] (panel.ph1_ind && panel.ph2_ind))
    else $error("third phase not reached after copy");
  a_exec_addr: assert property (start_exec |-> start_addr == 20'h0_0010 && central_control_unit.l1_request ##1 !start_exec)
    else $error("entry address or level request wrong");
  c_copy: cover property ($rose(cs_req));
  c_exec: cover property (start_exec);
  c_stop: cover property ($rose(panel.hard_stop));
endmodule
`default_nettype wire

// File: verification/ripl_mem_model.sv
// storage side model: rom contents and cycle steal acknowledge
`timescale 1ns/10ps
`default_nettype none
module ripl_mem_model
#(
  parameter int NBYTES = 1024
)
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // rom and storage
  input wire logic [9:0] rom_addr,
  output logic [7:0] rom_data,
  input wire logic cs_req,
  input wire logic [19:0] cs_addr,
  input wire logic [7:0] cs_data,
  output logic cs_ack
);
  logic [7:0] mem [0:1023]; // main storage image
  int nwr = 0; // bytes stored since start
  int bad = 0; // stores out of sequence
  // fixed pattern so every address within a 256-byte block differs
  assign rom_data = rom_addr[7:0] ^ {rom_addr[9:8], 6'h2d};
  // random pace; never two edges running, so slow and quick both occur
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
      cs_ack <= 1'b0;
    else
      cs_ack <= cs_req && !cs_ack && ($urandom_range(0, 1) == 1);
  // one byte taken per acknowledged storage cycle
  always @(posedge hclk)
    if (hresetn && cs_req && cs_ack)
    begin
      if (cs_addr != 20'(nwr % NBYTES))
        bad <= bad + 1;
      mem[cs_addr[9:0]] <= cs_data;
      nwr <= nwr + 1;
    end
endmodule
`default_nettype wire

// File: verification/tb_remote_ipl_bootstrap_sequencer.sv
// self-checking bench for the remote load sequencer
`timescale 1ns/10ps
`default_nettype none
module tb_remote_ipl_bootstrap_sequencer;
  localparam int NB = 16; // shortened copy keeps the run brief
  logic hclk, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, hreadyout, hresp;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = 3'b010;
  logic [31:0] haddr = 32'h0000_0000, hwdata = 32'h0000_0000, hrdata, rd;
  logic diag_process = 1'b1, load_button = 1'b0, power_on_button = 1'b0, unit_check = 1'b0;
  logic adapters_disabled = 1'b0, adapter_switches_off = 1'b0;
  logic cs_req, cs_ack, start_exec, irq;
  logic [9:0] rom_addr;
  logic [7:0] rom_data, cs_data, err_display, code;
  logic [19:0] cs_addr, start_addr;
  ripl_pkg::ripl_panel_t panel;
  ripl_pkg::ripl_ccu_t central_control_unit;
  int mismatches = 0, checks_done = 0;
  assign hready = hreadyout; // single slave
  ripl_seq #(.NBYTES(NB)) u_ripl_seq (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .diag_process, .load_button,
    .power_on_button, .unit_check, .adapters_disabled, .adapter_switches_off, .rom_addr,
    .rom_data, .cs_req, .cs_addr, .cs_data, .cs_ack, .panel, .central_control_unit, .start_addr,
    .start_exec, .err_display, .irq);
  ripl_mem_model #(.NBYTES(NB)) u_ripl_mem_model (.hclk, .hresetn, .rom_addr, .rom_data,
    .cs_req, .cs_addr, .cs_data, .cs_ack);
  // 20 MHz clock
  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one single-word transfer; waits on hready, never on a fixed count
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask
  // expected rom byte at an index
  function automatic logic [7:0] exp_byte(input logic [9:0] i);
    return i[7:0] ^ {i[9:8], 6'h2d};
  endfunction
  // loader rom chosen by latched program start or all adapters off
  function automatic logic exp_sel(input int k, input logic l, input logic ad, input logic ao);
    return (k == 3 && l) || (ad && ao);
  endfunction
  // verdict and end of run
  task automatic results();
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard, well past four loads
  initial
  begin
    #2000000;
    mismatches++;
    results();
  end
  // main sequence
  initial
  begin
    logic l, en, ad, ao;
    int n;
    void'($urandom(32'h0d73_9d6f));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, 32'h0000_0004, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    ahb(1'b1, 32'h0000_0020, 32'h0000_0010);
    ahb(1'b0, 32'h0000_0020, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    ahb(1'b0, 32'h0000_0000, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk({hreadyout, hresp}, 2'b10);
    // button pressed with the switch away from process
    diag_process <= 1'b0;
    load_button <= 1'b1;
    repeat (6) @(posedge hclk);
    #1 chk(panel.load_ind, 1'b0);
    load_button <= 1'b0;
    diag_process <= 1'b1;
    // every start source, random adapter state, latch and mask
    for (int k = 0; k < 4; k++)
    begin
      l = 1'($urandom_range(0, 1));
      en = 1'($urandom_range(0, 1));
      ad = 1'($urandom_range(0, 1));
      ao = 1'($urandom_range(0, 1));
      adapters_disabled <= ad;
      adapter_switches_off <= ao;
      ahb(1'b1, 32'h0000_0010, {28'h000_0000, {4{en}}});
      ahb(1'b1, 32'h0000_0000, {27'h000_0000, l, 4'h0});
      case (k)
        0: load_button <= 1'b1;
        1: power_on_button <= 1'b1;
        2: unit_check <= 1'b1;
        default: ahb(1'b1, 32'h0000_0000, {27'h000_0000, l, 4'h4});
      endcase
      n = 0;
      while (start_exec !== 1'b1 && n < 4000)
      begin
        @(posedge hclk);
        #1 n++;
      end
      load_button <= 1'b0;
      power_on_button <= 1'b0;
      unit_check <= 1'b0;
      chk(start_addr, 32'h0000_0010);
      chk({panel.ph1_ind, panel.ph2_ind, central_control_unit.l1_request, panel.rom_sel}, {3'b111, exp_sel(k, l, ad, ao)});
      chk(u_ripl_mem_model.nwr, NB * (k + 1));
      chk(u_ripl_mem_model.bad, 0);
      for (int i = 0; i < NB; i++)
        chk(u_ripl_mem_model.mem[i], exp_byte(10'(i)));
      ahb(1'b0, 32'h0000_0008, 32'h0000_0000);
      chk(rd, {28'h000_0000, k == 2, 3'b011});
      chk(irq, en);
      ahb(1'b1, 32'h0000_000C, 32'h0000_000F);
      ahb(1'b0, 32'h0000_0008, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      #1 chk(irq, 1'b0);
    end
    // bootstrap error while running
    code = 8'($urandom);
    ahb(1'b1, 32'h0000_0000, {8'h00, code, 16'h0100});
    repeat (2) @(posedge hclk);
    #1 chk({panel.hard_stop, err_display}, {1'b1, code});
    ahb(1'b0, 32'h0000_0014, 32'h0000_0000);
    chk(rd, {24'h00_0000, code});
    results();
  end
endmodule
bind ripl_seq ripl_chk #(.NBYTES(NBYTES)) u_ripl_chk (.hclk, .hresetn, .diag_process,
  .rom_data, .cs_req, .cs_addr, .cs_data, .cs_ack, .panel, .central_control_unit, .start_addr, .start_exec);
`default_nettype wire
